// ---- logic/dmas_pkg.sv ----
package dmas_pkg;
    // register indices (printed offsets); byte address is index * 4
    localparam logic [2:0] DMAS_IDX_STATUS = 3'h0;
    localparam logic [2:0] DMAS_IDX_RDADDR = 3'h1;
    localparam logic [2:0] DMAS_IDX_WRADDR = 3'h2;
    localparam logic [2:0] DMAS_IDX_LENGTH = 3'h3;
    localparam logic [2:0] DMAS_IDX_IRQMASK = 3'h4;
    localparam logic [2:0] DMAS_IDX_CONTROL = 3'h6;
    localparam int DMAS_ADDR_W = 5;
    // status bit positions
    localparam int DMAS_ST_DONE = 0;
    localparam int DMAS_ST_BUSY = 1;
    localparam int DMAS_ST_LEN = 4;
    // control bit positions
    localparam int DMAS_CT_BYTE = 0;
    localparam int DMAS_CT_HW = 1;
    localparam int DMAS_CT_WORD = 2;
    localparam int DMAS_CT_GO = 3;
    localparam int DMAS_CT_IEN = 4;
    localparam int DMAS_CT_RHOLD = 8;
    localparam int DMAS_CT_WHOLD = 9;
    localparam int DMAS_CT_DWORD = 10;
    localparam int DMAS_CT_QWORD = 11;
    localparam int DMAS_CT_SWRST = 12;
    localparam int DMAS_CT_W = 13;
    localparam logic [12:0] DMAS_CT_RST = 13'h0000;
    localparam logic [4:0] DMAS_MASK_RST = 5'h00;
    // width enable bits: byte, half, word, dword, qword
    localparam logic [4:0] DMAS_WIDTHS_ALL = 5'h1F;
    // transfer width codes
    typedef enum logic [2:0] {
        DMAS_W_BYTE = 3'b000,
        DMAS_W_HALF = 3'b001,
        DMAS_W_WORD = 3'b010,
        DMAS_W_DWORD = 3'b011,
        DMAS_W_QWORD = 3'b100,
        DMAS_W_NONE = 3'b111
    } dmas_width_t;
    typedef enum logic [1:0] {
        DMAS_S_IDLE = 2'b00,
        DMAS_S_RUN = 2'b01,
        DMAS_S_DRAIN = 2'b10
    } dmas_state_t;
endpackage

// ---- logic/dmas_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dmas_fifo_if #(parameter int DW = 32);
    logic wr_valid;
    logic wr_ready;
    logic [DW-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [DW-1:0] rd_data;
    logic flush;
    modport engine(output wr_valid, output wr_data, input wr_ready,
                   input rd_valid, input rd_data, output rd_ready, output flush);
    modport store(input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready, input flush);
endinterface
`default_nettype wire

// ---- logic/dmas_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmas_fifo #(
    parameter int DW = 32,
    parameter int DEPTH = 2,
    parameter bit USE_REGS = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // both sides of the buffer
    dmas_fifo_if.store f
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    logic [DW-1:0] rdq;

    assign f.wr_ready = (cnt_r != (AW+1)'(DEPTH));
    assign f.rd_valid = (cnt_r != '0);
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_valid && f.rd_ready;

    generate
        if (USE_REGS) begin : g_regs
            // one flip-flop per stored bit, cleared by reset
            logic [DW-1:0] mem_r [DEPTH];
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    for (int i = 0; i < DEPTH; i++) begin
                        mem_r[i] <= '0;
                    end
                end else if (push) begin
                    mem_r[wp_r] <= f.wr_data;
                end
            end
            assign rdq = mem_r[rp_r];
        end else begin : g_ram
            // memory array with no reset, maps onto embedded blocks
            logic [DW-1:0] mem [DEPTH];
            always_ff @(posedge clk_sys) begin
                if (push) begin
                    mem[wp_r] <= f.wr_data;
                end
            end
            assign rdq = mem[rp_r];
        end
    endgenerate
    assign f.rd_data = rdq;

    // pointer and count next values
    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (f.flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
            end
            if (push && !pop) begin
                cnt_nxt = cnt_r + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_nxt = cnt_r - (AW+1)'(1);
            end
        end
    end

    // pointer registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- logic/dmas_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmas_engine
    import dmas_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int LEN_W = ADDR_W,
    parameter int DATA_W = 32,
    parameter int FIFO_DEPTH = 2,
    parameter bit FIFO_REGS = 1'b0,
    parameter bit BURST_EN = 1'b0,
    parameter int MAX_BURST = 16,
    parameter logic [4:0] WIDTHS_EN = dmas_pkg::DMAS_WIDTHS_ALL
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [dmas_pkg::DMAS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic irq,
    // read host port
    output logic [ADDR_W-1:0] rd_address,
    output logic rd_read,
    output logic [$clog2(MAX_BURST+1)-1:0] rd_burstcount,
    input wire logic rd_waitrequest,
    input wire logic rd_datavalid,
    input wire logic [DATA_W-1:0] rd_readdata,
    // write host port
    output logic [ADDR_W-1:0] wr_address,
    output logic wr_write,
    output logic [$clog2(MAX_BURST+1)-1:0] wr_burstcount,
    output logic [DATA_W-1:0] wr_writedata,
    input wire logic wr_waitrequest
);
    import dmas_pkg::*;
    localparam int BC_W = $clog2(MAX_BURST+1);
    localparam int IW = $clog2(FIFO_DEPTH+1);
    localparam int DBYTES = DATA_W / 8;
    localparam int DSH = $clog2(DBYTES);

    // decode the one-hot width bits of a control word, honouring build options
    function automatic dmas_width_t width_of(input logic [DMAS_CT_W-1:0] c);
        dmas_width_t w;
        w = DMAS_W_NONE;
        if (c[DMAS_CT_QWORD] && WIDTHS_EN[4]) w = DMAS_W_QWORD;
        else if (c[DMAS_CT_DWORD] && WIDTHS_EN[3]) w = DMAS_W_DWORD;
        else if (c[DMAS_CT_WORD] && WIDTHS_EN[2]) w = DMAS_W_WORD;
        else if (c[DMAS_CT_HW] && WIDTHS_EN[1]) w = DMAS_W_HALF;
        else if (c[DMAS_CT_BYTE] && WIDTHS_EN[0]) w = DMAS_W_BYTE;
        return w;
    endfunction

    // per-access address step; used for both ports
    function automatic logic [ADDR_W-1:0] step_of(input logic hold, input dmas_width_t w);
        logic [ADDR_W-1:0] s;
        s = '0;
        if (hold) s = '0;
        else begin
            case (w)
                DMAS_W_BYTE: s = ADDR_W'(1);
                DMAS_W_HALF: s = ADDR_W'(2);
                DMAS_W_WORD: s = ADDR_W'(4);
                DMAS_W_DWORD: s = ADDR_W'(8);
                DMAS_W_QWORD: s = ADDR_W'(16);
                default: s = '0; // undefined, zero chosen
            endcase
        end
        return s;
    endfunction

    dmas_fifo_if #(.DW(DATA_W)) fq ();

    // register state
    logic [DMAS_CT_W-1:0] ctl_r, ctl_nxt;
    logic [ADDR_W-1:0] rdst_r, rdst_nxt, wrst_r, wrst_nxt;
    logic [LEN_W-1:0] len_r, len_nxt;
    logic done_r, done_nxt, lenz_r, lenz_nxt;
    logic [4:0] mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // engine state
    dmas_state_t st_r, st_nxt;
    logic [ADDR_W-1:0] ra_r, ra_nxt, wa_r, wa_nxt;
    logic [LEN_W-1:0] rrem_r, rrem_nxt;
    logic [BC_W-1:0] bc_r, bc_nxt;
    logic rburst_r, rburst_nxt, wburst_r, wburst_nxt;
    logic [IW-1:0] infl_r, infl_nxt;

    dmas_width_t wid;
    logic [ADDR_W-1:0] rstep, wstep;
    logic [LEN_W-1:0] wbytes;
    logic busy, go_wr, rd_acc, wr_acc, sw_rst;
    logic [4:0] status;

    assign wid = width_of(ctl_r);
    assign rstep = step_of(ctl_r[DMAS_CT_RHOLD], wid);
    assign wstep = step_of(ctl_r[DMAS_CT_WHOLD], wid);
    assign busy = (st_r != DMAS_S_IDLE);
    assign sw_rst = reg_wr && (reg_addr[4:2] == DMAS_IDX_CONTROL) && reg_wdata[DMAS_CT_SWRST];
    assign go_wr = reg_wr && (reg_addr[4:2] == DMAS_IDX_CONTROL) && reg_wdata[DMAS_CT_GO]
                   && !busy && !sw_rst;
    // bytes carried by one data value of the chosen width
    always_comb begin
        case (wid)
            DMAS_W_BYTE: wbytes = LEN_W'(1);
            DMAS_W_HALF: wbytes = LEN_W'(2);
            DMAS_W_WORD: wbytes = LEN_W'(4);
            DMAS_W_DWORD: wbytes = LEN_W'(8);
            DMAS_W_QWORD: wbytes = LEN_W'(16);
            default: wbytes = LEN_W'(1);
        endcase
    end
    assign status = {lenz_r, 2'b00, busy, done_r};

    // host port drive
    // single reads owed to the buffer stay within its depth, so no word is lost; a burst read only waits for one free slot
    // and a stalled read request cannot drop while it waits
    assign rd_read = (st_r == DMAS_S_RUN) && (rrem_r != '0) && (!rburst_r || bc_r == '0)
                     && (rburst_r ? fq.wr_ready : (infl_r != IW'(FIFO_DEPTH)));
    assign rd_acc = rd_read && !rd_waitrequest;
    assign rd_address = ra_r;
    assign wr_address = wa_r;
    assign wr_write = busy && fq.rd_valid && (len_r != '0);
    assign wr_acc = wr_write && !wr_waitrequest;
    assign wr_writedata = fq.rd_data;
    assign fq.wr_valid = rd_datavalid && busy;
    assign fq.wr_data = rd_readdata;
    assign fq.rd_ready = wr_acc;
    assign fq.flush = sw_rst || go_wr;
    // burst count in data port units, capped at the maximum
    assign rd_burstcount = BURST_EN ? (((len_r >> DSH) > LEN_W'(MAX_BURST)) ? BC_W'(MAX_BURST)
                                       : BC_W'(len_r >> DSH)) : BC_W'(1);
    assign wr_burstcount = rd_burstcount;
    assign reg_rdata = rdata_r;
    assign irq = |(status & mask_r) || (done_r && ctl_r[DMAS_CT_IEN]);

    // register file next values
    always_comb begin
        ctl_nxt = ctl_r;
        rdst_nxt = rdst_r;
        wrst_nxt = wrst_r;
        len_nxt = len_r;
        done_nxt = done_r;
        lenz_nxt = lenz_r;
        mask_nxt = mask_r;
        rdata_nxt = '0;
        if (reg_rd) begin
            case (reg_addr[4:2])
                DMAS_IDX_STATUS: rdata_nxt = {27'h0000000, status};
                DMAS_IDX_RDADDR: rdata_nxt = 32'(rdst_r);
                DMAS_IDX_WRADDR: rdata_nxt = 32'(wrst_r);
                DMAS_IDX_LENGTH: rdata_nxt = 32'(len_r);
                DMAS_IDX_IRQMASK: rdata_nxt = {27'h0000000, mask_r};
                DMAS_IDX_CONTROL: rdata_nxt = {19'h00000, ctl_r};
                default: rdata_nxt = '0;
            endcase
            // reading status clears its sticky bits
            if (reg_addr[4:2] == DMAS_IDX_STATUS) begin
                done_nxt = 1'b0;
                lenz_nxt = 1'b0;
            end
        end
        if (reg_wr) begin
            case (reg_addr[4:2])
                DMAS_IDX_STATUS: begin
                    done_nxt = 1'b0;
                    lenz_nxt = 1'b0;
                end
                DMAS_IDX_RDADDR: rdst_nxt = reg_wdata[ADDR_W-1:0];
                DMAS_IDX_WRADDR: wrst_nxt = reg_wdata[ADDR_W-1:0];
                DMAS_IDX_LENGTH: len_nxt = reg_wdata[LEN_W-1:0];
                DMAS_IDX_IRQMASK: mask_nxt = reg_wdata[4:0];
                DMAS_IDX_CONTROL: ctl_nxt = reg_wdata[DMAS_CT_W-1:0] & ~13'h1000;
                default: ;
            endcase
        end
        // count down per written value, clamp at zero
        if (wr_acc) begin
            len_nxt = (len_r > wbytes) ? len_r - wbytes : '0;
            if (len_r <= wbytes) begin
                lenz_nxt = 1'b1;
                done_nxt = 1'b1;
            end
        end
        if (sw_rst) begin
            ctl_nxt = DMAS_CT_RST;
            done_nxt = 1'b0;
            lenz_nxt = 1'b0;
        end
    end

    // engine next values
    always_comb begin
        st_nxt = st_r;
        ra_nxt = ra_r;
        wa_nxt = wa_r;
        rrem_nxt = rrem_r;
        bc_nxt = bc_r;
        rburst_nxt = rburst_r;
        wburst_nxt = wburst_r;
        infl_nxt = infl_r;
        case (st_r)
            DMAS_S_IDLE: begin
                if (go_wr) begin
                    ra_nxt = rdst_r;
                    wa_nxt = wrst_r;
                    rrem_nxt = len_r;
                    st_nxt = DMAS_S_RUN;
                    // bursts on both ports when built in
                    rburst_nxt = BURST_EN;
                    wburst_nxt = BURST_EN;
                    infl_nxt = '0;
                end
            end
            DMAS_S_RUN, DMAS_S_DRAIN: begin
                // read address steps only on its own accepted access
                if (rd_acc) begin
                    if (!rburst_r) begin
                        ra_nxt = ra_r + rstep;
                        rrem_nxt = (rrem_r > wbytes) ? rrem_r - wbytes : '0;
                    end else begin
                        bc_nxt = rd_burstcount;
                        rrem_nxt = '0;
                    end
                end
                if (rburst_r && rd_datavalid && bc_r != '0) begin
                    bc_nxt = bc_r - BC_W'(1);
                end
                // write address steps only on accepted writes
                if (wr_acc && !wburst_r) begin
                    wa_nxt = wa_r + wstep;
                end
                // accepted reads not yet written out
                if (rd_acc && !rburst_r && !(wr_acc && !wburst_r)) begin
                    infl_nxt = infl_r + IW'(1);
                end else if (wr_acc && !wburst_r && !(rd_acc && !rburst_r)) begin
                    infl_nxt = infl_r - IW'(1);
                end
                if (rrem_r == '0 && st_r == DMAS_S_RUN) begin
                    st_nxt = DMAS_S_DRAIN;
                end
                if (len_r == '0 || (wr_acc && len_r <= wbytes)) begin
                    st_nxt = DMAS_S_IDLE;
                end
            end
            default: st_nxt = DMAS_S_IDLE;
        endcase
        if (sw_rst) begin
            st_nxt = DMAS_S_IDLE;
            infl_nxt = '0;
        end
    end

    // register all state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl_r <= DMAS_CT_RST;
            rdst_r <= '0;
            wrst_r <= '0;
            len_r <= '0;
            done_r <= 1'b0;
            lenz_r <= 1'b0;
            mask_r <= DMAS_MASK_RST;
            rdata_r <= '0;
            st_r <= DMAS_S_IDLE;
            ra_r <= '0;
            wa_r <= '0;
            rrem_r <= '0;
            bc_r <= '0;
            rburst_r <= 1'b0;
            wburst_r <= 1'b0;
            infl_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
            rdst_r <= rdst_nxt;
            wrst_r <= wrst_nxt;
            len_r <= len_nxt;
            done_r <= done_nxt;
            lenz_r <= lenz_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
            ra_r <= ra_nxt;
            wa_r <= wa_nxt;
            rrem_r <= rrem_nxt;
            bc_r <= bc_nxt;
            rburst_r <= rburst_nxt;
            wburst_r <= wburst_nxt;
            infl_r <= infl_nxt;
        end
    end

    dmas_fifo #(
        .DW(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .USE_REGS(FIFO_REGS)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .f(fq.store)
    );
endmodule
`default_nettype wire

// ---- bench/dmas_engine_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmas_engine_monitor
    import dmas_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [dmas_pkg::DMAS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // host ports
    input wire logic [ADDR_W-1:0] rd_address,
    input wire logic rd_read,
    input wire logic rd_waitrequest,
    input wire logic [ADDR_W-1:0] wr_address,
    input wire logic wr_write,
    input wire logic [DATA_W-1:0] wr_writedata,
    input wire logic wr_waitrequest
);
    logic [12:0] ctl_r;
    logic [12:0] ctl_nxt;
    logic [31:0] left_r;
    logic [31:0] left_nxt;
    logic [4:0] wstep;
    logic [ADDR_W-1:0] astep;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // width step, widest selected width wins
    assign wstep = ctl_r[DMAS_CT_QWORD] ? 5'h10 : ctl_r[DMAS_CT_DWORD] ? 5'h08 :
        ctl_r[DMAS_CT_WORD] ? 5'h04 : ctl_r[DMAS_CT_HW] ? 5'h02 : {4'h0, ctl_r[DMAS_CT_BYTE]};
    assign astep = {{(ADDR_W-5){1'b0}}, wstep};
    // shadow of control and of the bytes still to write
    always_comb begin
        ctl_nxt = ctl_r;
        left_nxt = left_r;
        if (reg_wr && reg_addr[4:2] == DMAS_IDX_CONTROL) begin
            ctl_nxt = reg_wdata[12:0];
        end
        if (reg_wr && reg_addr[4:2] == DMAS_IDX_LENGTH) begin
            left_nxt = reg_wdata;
        end else if (wr_write && !wr_waitrequest && left_r >= {27'h0, wstep}) begin
            left_nxt = left_r - {27'h0, wstep};
        end
    end
    // shadow registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl_r <= 13'h0000;
            left_r <= 32'h0;
        end else begin
            ctl_r <= ctl_nxt;
            left_r <= left_nxt;
        end
    end
    sequence s_rd_acc;
        rd_read && !rd_waitrequest;
    endsequence
    sequence s_wr_acc;
        wr_write && !wr_waitrequest;
    endsequence
    sequence s_last_wr;
        s_wr_acc ##0 left_r == {27'h0, wstep};
    endsequence
    property p_rd_hold;
        s_rd_acc ##0 ctl_r[DMAS_CT_RHOLD] |=> $stable(rd_address);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read address moved under hold");
    property p_wr_hold;
        s_wr_acc ##0 ctl_r[DMAS_CT_WHOLD] |=> $stable(wr_address);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write address moved under hold");
    property p_rd_step;
        s_rd_acc ##0 !ctl_r[DMAS_CT_RHOLD] |=> rd_address == $past(rd_address) + astep;
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read address step wrong");
    property p_wr_step;
        s_wr_acc ##0 !ctl_r[DMAS_CT_WHOLD] |=> wr_address == $past(wr_address) + astep;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("write address step wrong");
    property p_rd_stand;
        rd_read && rd_waitrequest |=> rd_read && $stable(rd_address);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read request dropped early");
    property p_wr_stand;
        wr_write && wr_waitrequest |=> wr_write && $stable(wr_address) && $stable(wr_writedata);
    endproperty
    a_wr_stand: assert property (p_wr_stand) else $error("write request dropped early");
    property p_wr_within;
        wr_write |-> left_r != 32'h0;
    endproperty
    a_wr_within: assert property (p_wr_within) else $error("write past zero length");
    property p_len_quiet;
        s_last_wr |=> !wr_write [*4];
    endproperty
    a_len_quiet: assert property (p_len_quiet) else $error("write after length end");
endmodule
`default_nettype wire

// ---- bench/dmas_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmas_mem_model #(
    parameter int AW = 16
) (
    // clock, reset, pace
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slow,
    // read side
    input wire logic [AW-1:0] rd_address,
    input wire logic rd_read,
    output logic rd_waitrequest,
    output logic rd_datavalid,
    output logic [31:0] rd_readdata,
    // write side
    input wire logic [AW-1:0] wr_address,
    input wire logic wr_write,
    input wire logic [31:0] wr_writedata,
    output logic wr_waitrequest
);
    logic [AW-1:0] rd_log [64];
    logic [AW-1:0] wr_log [64];
    logic [31:0] wd_log [64];
    logic [31:0] pq [$];
    int rd_n;
    int wr_n;
    logic [1:0] tick;
    initial begin
        rd_n = 0;
        wr_n = 0;
        tick = 2'h0;
        rd_waitrequest = 1'b0;
        rd_datavalid = 1'b0;
        rd_readdata = 32'h0;
        wr_waitrequest = 1'b0;
    end
    // logs accesses, answers reads in order, stalls when slow
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pq.delete();
            rd_datavalid <= 1'b0;
        end else begin
            tick = tick + 2'h1;
            if (rd_read && !rd_waitrequest) begin
                rd_log[rd_n] = rd_address;
                rd_n = rd_n + 1;
                pq.push_back({16'h5A5A, rd_address});
            end
            if (wr_write && !wr_waitrequest) begin
                wr_log[wr_n] = wr_address;
                wd_log[wr_n] = wr_writedata;
                wr_n = wr_n + 1;
            end
            if (pq.size() > 0 && (!slow || tick[0])) begin
                rd_datavalid <= 1'b1;
                rd_readdata <= pq.pop_front();
            end else begin
                rd_datavalid <= 1'b0;
                rd_readdata <= ~rd_readdata;
            end
            rd_waitrequest <= slow && tick[1];
            wr_waitrequest <= slow && !tick[1];
        end
    end
endmodule
`default_nettype wire

// ---- bench/dma_address_step_and_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_address_step_and_config_tb;
    import dmas_pkg::*;
    localparam int AW = 16;
    logic clk_sys;
    logic resetn;
    logic slow;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic irq;
    logic [AW-1:0] rd_address;
    logic rd_read;
    logic rd_waitrequest;
    logic rd_datavalid;
    logic [31:0] rd_readdata;
    logic [AW-1:0] wr_address;
    logic wr_write;
    logic [31:0] wr_writedata;
    logic wr_waitrequest;
    logic [31:0] rv;
    logic [4:0] rbc;
    logic [4:0] wbc;
    int fails;
    int compares;
    dmas_engine #(.ADDR_W(AW), .LEN_W(AW), .DATA_W(32)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .rd_address(rd_address), .rd_read(rd_read), .rd_burstcount(rbc),
        .rd_waitrequest(rd_waitrequest), .rd_datavalid(rd_datavalid),
        .rd_readdata(rd_readdata), .wr_address(wr_address), .wr_write(wr_write),
        .wr_burstcount(wbc), .wr_writedata(wr_writedata), .wr_waitrequest(wr_waitrequest));
    dmas_mem_model #(.AW(AW)) u_mem (
        .clk_sys(clk_sys), .resetn(resetn), .slow(slow), .rd_address(rd_address),
        .rd_read(rd_read), .rd_waitrequest(rd_waitrequest), .rd_datavalid(rd_datavalid),
        .rd_readdata(rd_readdata), .wr_address(wr_address), .wr_write(wr_write),
        .wr_writedata(wr_writedata), .wr_waitrequest(wr_waitrequest));
    // system clock, 20 ns
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [2:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [2:0] idx, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= {idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // one three-access run, then address, data, status and interrupt checks
    task automatic xfer(input logic [12:0] ctl, input logic [4:0] step, input bit irqt);
        int rb;
        int wb;
        int i;
        logic [AW-1:0] ea;
        logic [AW-1:0] eb;
        rb = u_mem.rd_n;
        wb = u_mem.wr_n;
        // non-burst run, equal bus widths, starts aligned
        reg_write(DMAS_IDX_LENGTH, {27'h0, step} * 32'h3);
        reg_write(DMAS_IDX_RDADDR, 32'h0100);
        reg_write(DMAS_IDX_WRADDR, 32'h0400);
        reg_write(DMAS_IDX_CONTROL, {19'h0, ctl} | (32'h1 << DMAS_CT_GO));
        for (i = 0; i < 2000 && u_mem.wr_n < wb + 3; i++) @(posedge clk_sys);
        if (u_mem.wr_n < wb + 3) begin
            fails++;
            end_sim;
        end
        repeat (6) @(posedge clk_sys);
        check(32'(u_mem.rd_n - rb), 32'h3);
        check(32'(u_mem.wr_n - wb), 32'h3);
        for (i = 0; i < 3; i++) begin
            ea = 16'h0100 + (ctl[DMAS_CT_RHOLD] ? 16'h0 : 16'(i) * {11'h0, step});
            eb = 16'h0400 + (ctl[DMAS_CT_WHOLD] ? 16'h0 : 16'(i) * {11'h0, step});
            check({16'h0, u_mem.rd_log[rb + i]}, {16'h0, ea});
            check({16'h0, u_mem.wr_log[wb + i]}, {16'h0, eb});
            check(u_mem.wd_log[wb + i], {16'h5A5A, ea});
        end
        if (irqt) begin
            check({31'h0, irq}, 32'h0);
            reg_write(DMAS_IDX_IRQMASK, 32'h1);
            @(posedge clk_sys);
            #1;
            check({31'h0, irq}, 32'h1);
        end
        reg_read(DMAS_IDX_STATUS, rv);
        check(rv, (32'h1 << DMAS_ST_DONE) | (32'h1 << DMAS_ST_LEN));
        if (irqt) begin
            @(posedge clk_sys);
            #1;
            check({31'h0, irq}, 32'h0);
            reg_write(DMAS_IDX_IRQMASK, 32'h0);
        end
        reg_read(DMAS_IDX_LENGTH, rv);
        check(rv, 32'h0);
        reg_read(DMAS_IDX_STATUS, rv);
        check(rv, 32'h0);
    endtask
    // main sequence
    initial begin
        fails = 0;
        compares = 0;
        resetn = 1'b0;
        slow = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        reg_read(DMAS_IDX_CONTROL, rv);
        check(rv, {19'h0, DMAS_CT_RST});
        reg_write(3'h5, 32'hFFFF);
        reg_read(3'h5, rv);
        check(rv, 32'h0);
        xfer(13'h0001, 5'h01, 1'b1);
        xfer(13'h0002, 5'h02, 1'b0);
        xfer(13'h0004, 5'h04, 1'b0);
        xfer(13'h0400, 5'h08, 1'b0);
        xfer(13'h0800, 5'h10, 1'b0);
        @(posedge clk_sys);
        slow <= 1'b1;
        xfer(13'h0104, 5'h04, 1'b0);
        xfer(13'h0201, 5'h01, 1'b0);
        xfer(13'h0B00, 5'h10, 1'b0);
        // soft reset clears the stored control word, hold bits included
        reg_write(DMAS_IDX_CONTROL, (32'h1 << DMAS_CT_SWRST) | 32'h0304);
        reg_read(DMAS_IDX_CONTROL, rv);
        check(rv, {19'h0, DMAS_CT_RST});
        // no bursts built in: both counts stay at one
        check({27'h0, rbc}, 32'h1);
        check({27'h0, wbc}, 32'h1);
        end_sim;
    end
endmodule
bind dmas_engine dmas_engine_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .rd_address(rd_address), .rd_read(rd_read),
    .rd_waitrequest(rd_waitrequest), .wr_address(wr_address), .wr_write(wr_write),
    .wr_writedata(wr_writedata), .wr_waitrequest(wr_waitrequest));
`default_nettype wire
